// File: shared/serial_port_pkg.sv
// serial_port_pkg: register map, field positions, dividers, modes.
// assumes: one 125 MHz clock, registers reached over AXI4-Lite.
// Operation
// - set framing error flag when a received frame ends with bad stop bit
// - valid stop bit never clears framing error; only software clears it
// - control bit 7 is framing error if select set, else mode bit 0
// - mode 00: shift register at clock/12, or /6 in double speed
// - mode 01: 8-bit UART, variable rate
// - mode 10: 9-bit UART at /64 or /32, halved in double speed
// - mode 11: 9-bit UART, variable rate
// - multiprocessor filter in modes 2, 3 and optionally 1; off in mode 0
// - receive only while receive enable is set
// - modes 2 and 3 send the tx ninth bit as ninth data bit
// - modes 2 and 3 load the received ninth bit into rx ninth bit
// - mode 1 without filter: rx ninth bit takes the stop bit
// - tx done set after 8th bit in mode 0, at stop start otherwise
// - mode 0: rx done set at end of eighth received bit
// - control register resets to zero and allows single-bit writes
// - power control: double rate bit 7, error select bit 6, bit 5 unused
`default_nettype none

package serial_port_pkg;
	typedef enum logic [1:0] {
		MODE_SHIFT  = 2'b00,
		MODE_UART8  = 2'b01,
		MODE_UART9  = 2'b10,
		MODE_UART9V = 2'b11
	} mode_t;

	localparam int         ADDR_W             = 10;
	localparam logic [7:0] POWER_CONTROL_IDX  = 8'h87;
	localparam logic [7:0] SERIAL_CONTROL_IDX = 8'h98;
	localparam logic [7:0] DATA_BUFFER_IDX    = 8'h99;
	localparam logic [7:0] BIT_ACCESS_IDX     = 8'h9a;

	localparam int SC_FE_SM0 = 7;
	localparam int SC_SM1    = 6;
	localparam int SC_SM2    = 5;
	localparam int SC_REN    = 4;
	localparam int SC_TB8    = 3;
	localparam int SC_RB8    = 2;
	localparam int SC_TI     = 1;
	localparam int SC_RI     = 0;
	localparam int PC_BAUD_DOUBLE_SELECT  = 7;
	localparam int PC_FRAME_ERROR_SELECT  = 6;
	localparam int BA_VALUE  = 3;

	localparam logic [7:0] SERIAL_CONTROL_RST = 8'h00;
	localparam logic [4:0] POWER_FLAGS_RST    = 5'h10;

	localparam int         DIV_MIN_W      = 3;
	localparam logic [2:0] DIV_M0         = 3'h6;
	localparam logic [2:0] DIV_M0_X2      = 3'h3;
	localparam logic [2:0] DIV_M2         = 3'h4;
	localparam logic [2:0] DIV_M2_SMOD    = 3'h2;
	localparam logic [2:0] DIV_M2_X2      = 3'h2;
	localparam logic [2:0] DIV_M2_SMOD_X2 = 3'h1;
	localparam logic [2:0] DIV_TIMER      = 3'h2;
	localparam logic [2:0] DIV_TIMER_SMOD = 3'h1;

	localparam logic [3:0] SAMPLE_POINT  = 4'h8;
	localparam logic [3:0] LAST_PHASE    = 4'hf;
	localparam logic [3:0] M0_LAST_BIT   = 4'h7;
	localparam logic [3:0] STOP_IDX_8    = 4'h9;
	localparam logic [3:0] STOP_IDX_9    = 4'ha;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : serial_port_pkg

`default_nettype wire

// File: rtl/baud_tick_gen.sv
// baud_tick_gen: sample tick (async) or half-bit tick (mode 0).
// assumes: timer_tick is a one-cycle pulse synchronous to clk.
`default_nettype none

module baud_tick_gen
	import serial_port_pkg::*;
#(
	parameter int DIV_W = 3
) (
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire mode_t mode,
	input  wire logic  baud_double,
	input  wire logic  double_speed,
	input  wire logic  timer_tick,
	input  wire logic  restart,
	output logic       tick
);
	logic [DIV_W-1:0] cnt_reg;
	logic [DIV_W-1:0] cnt_next;
	logic [DIV_W-1:0] div;
	logic             tick_reg;
	logic             tick_next;
	logic             step;

	if (DIV_W < DIV_MIN_W) begin : g_bad_width
		$error("baud_tick_gen: DIV_W too small");
	end

	always_comb begin
		case (mode)
		MODE_SHIFT: div = DIV_W'(double_speed ? DIV_M0_X2 : DIV_M0);
		MODE_UART9: begin
			if (double_speed)
				div = DIV_W'(baud_double ? DIV_M2_SMOD_X2 : DIV_M2_X2);
			else
				div = DIV_W'(baud_double ? DIV_M2_SMOD : DIV_M2);
		end
		default: div = DIV_W'(baud_double ? DIV_TIMER_SMOD : DIV_TIMER);
		endcase
		// timer-driven rate in modes 1 and 3
		step = (mode == MODE_UART8 || mode == MODE_UART9V) ?
			timer_tick : 1'b1;
		cnt_next  = cnt_reg;
		tick_next = 1'b0;
		if (restart) begin
			cnt_next = '0;
		end else if (step) begin
			if (cnt_reg >= div - DIV_W'(1)) begin
				cnt_next  = '0;
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + DIV_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule : baud_tick_gen

`default_nettype wire

// File: rtl/rx_frame.sv
// rx_frame: 16x oversampled asynchronous frame receiver.
// assumes: tick is the sample tick, rxd synchronous to clk.
`default_nettype none

module rx_frame
	import serial_port_pkg::*;
#(
	parameter int DATA_BITS = 8
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 enable,
	input  wire logic                 tick,
	input  wire logic                 rxd,
	input  wire logic                 nine_bit,
	output logic                      done,
	output logic [DATA_BITS-1:0]      data_out,
	output logic                      ninth_out,
	output logic                      stop_out
);
	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA  = 4'b0100,
		RX_STOP  = 4'b1000
	} rx_state_t;

	rx_state_t            state_reg, state_next;
	logic [3:0]           phase_reg, phase_next;
	logic [3:0]           cnt_reg, cnt_next;
	logic [DATA_BITS:0]   shift_reg, shift_next;
	logic [DATA_BITS-1:0] data_reg, data_next;
	logic                 done_reg, done_next;
	logic                 ninth_reg, ninth_next;
	logic                 stop_reg, stop_next;
	logic [3:0]           last_bit;

	if (DATA_BITS < 1 || DATA_BITS > 14) begin : g_bad_bits
		$error("rx_frame: DATA_BITS out of range");
	end

	always_comb begin
		state_next = state_reg;
		phase_next = phase_reg;
		cnt_next   = cnt_reg;
		shift_next = shift_reg;
		data_next  = data_reg;
		ninth_next = ninth_reg;
		stop_next  = stop_reg;
		done_next  = 1'b0;
		last_bit   = nine_bit ? 4'(DATA_BITS) : 4'(DATA_BITS - 1);
		if (!enable) begin
			state_next = RX_IDLE;
		end else if (tick) begin
			case (state_reg)
			RX_IDLE: begin
				if (!rxd) begin
					state_next = RX_START;
					phase_next = '0;
				end
			end
			RX_START: begin
				phase_next = phase_reg + 4'h1;
				// false start: line back high at mid bit
				if (phase_reg == SAMPLE_POINT && rxd) begin
					state_next = RX_IDLE;
				end else if (phase_reg == LAST_PHASE) begin
					state_next = RX_DATA;
					cnt_next   = '0;
				end
			end
			RX_DATA: begin
				phase_next = phase_reg + 4'h1;
				if (phase_reg == SAMPLE_POINT)
					shift_next = {rxd, shift_reg[DATA_BITS:1]};
				if (phase_reg == LAST_PHASE) begin
					cnt_next = cnt_reg + 4'h1;
					if (cnt_reg == last_bit)
						state_next = RX_STOP;
				end
			end
			RX_STOP: begin
				phase_next = phase_reg + 4'h1;
				if (phase_reg == SAMPLE_POINT) begin
					done_next  = 1'b1;
					stop_next  = rxd;
					state_next = RX_IDLE;
					if (nine_bit) begin
						data_next  = shift_reg[DATA_BITS-1:0];
						ninth_next = shift_reg[DATA_BITS];
					end else begin
						data_next  = shift_reg[DATA_BITS:1];
						ninth_next = rxd;
					end
				end
			end
			default: state_next = RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= RX_IDLE;
			phase_reg <= '0;
			cnt_reg   <= '0;
			shift_reg <= '0;
			data_reg  <= '0;
			done_reg  <= 1'b0;
			ninth_reg <= 1'b0;
			stop_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			cnt_reg   <= cnt_next;
			shift_reg <= shift_next;
			data_reg  <= data_next;
			done_reg  <= done_next;
			ninth_reg <= ninth_next;
			stop_reg  <= stop_next;
		end
	end

	assign done      = done_reg;
	assign data_out  = data_reg;
	assign ninth_out = ninth_reg;
	assign stop_out  = stop_reg;
endmodule : rx_frame

`default_nettype wire

// File: rtl/serial_port_control.sv
// serial_port_control: serial port with control/status registers.
// assumes: AXI4-Lite master, timer tick pulse and pins synchronous to CLK.
`default_nettype none

module serial_port_control
	import serial_port_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic [ADDR_W-1:0] AWADDR,
	input  wire logic              AWVALID,
	output logic                   AWREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	input  wire logic              WVALID,
	output logic                   WREADY,
	output logic [1:0]             BRESP,
	output logic                   BVALID,
	input  wire logic              BREADY,
	input  wire logic [ADDR_W-1:0] ARADDR,
	input  wire logic              ARVALID,
	output logic                   ARREADY,
	output logic [31:0]            RDATA,
	output logic [1:0]             RRESP,
	output logic                   RVALID,
	input  wire logic              RREADY,
	input  wire logic              TIMER_TICK,
	input  wire logic              DOUBLE_SPEED,
	output logic                   TXD,
	input  wire logic              RXD_IN,
	output logic                   RXD_OUT,
	output logic                   RXD_OE
);
	typedef enum logic [3:0] {
		ENG_IDLE  = 4'b0001,
		ENG_TX0   = 4'b0010,
		ENG_RX0   = 4'b0100,
		ENG_ASYNC = 4'b1000
	} eng_state_t;

	// ==========================================================
	// state
	logic              sm0_reg, sm0_next, sm1_reg, sm1_next;
	logic              sm2_reg, sm2_next, ren_reg, ren_next;
	logic              tb8_reg, tb8_next, rb8_reg, rb8_next;
	logic              ti_reg, ti_next, ri_reg, ri_next;
	logic              fe_reg, fe_next;
	logic              baud_double_select_reg, baud_double_select_next, frame_error_select_reg, frame_error_select_next;
	logic [4:0]        pflags_reg, pflags_next;
	logic [7:0]        rx_buf_reg, rx_buf_next;
	eng_state_t        eng_reg, eng_next;
	logic [9:0]        shift_reg, shift_next;
	logic [3:0]        bit_reg, bit_next, phase_reg, phase_next;
	logic              txd_reg, txd_next;
	logic              rxo_reg, rxo_next, oe_reg, oe_next;
	logic              awh_reg, awh_next, wh_reg, wh_next;
	logic [ADDR_W-1:0] awa_reg, awa_next;
	logic [7:0]        wd_reg, wd_next;
	logic              ws_reg, ws_next;
	logic              bv_reg, bv_next, rv_reg, rv_next;
	logic [1:0]        br_reg, br_next, rr_reg, rr_next;
	logic [7:0]        rd_reg, rd_next;

	// ==========================================================
	// decode and helpers
	mode_t      mode;
	logic       tick, rx_done, rx_ninth, rx_stop;
	logic [7:0] rx_data, sc_read, pc_read, sc_val, bit_mask;
	logic [7:0] wr_idx, rd_idx;
	logic       do_write, wr_sc, wr_bit, wr_pc, wr_data, wr_hit;
	logic       start_tx, start_rx0, restart, ti_set, ri_set;
	logic       rx_accept;
	logic [3:0] stop_idx;

	assign mode = mode_t'({sm0_reg, sm1_reg});
	assign sc_read = {frame_error_select_reg ? fe_reg : sm0_reg, sm1_reg, sm2_reg,
		ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg};
	assign pc_read = {baud_double_select_reg, frame_error_select_reg, 1'b0, pflags_reg};
	assign wr_idx   = awa_reg[ADDR_W-1:2];
	assign rd_idx   = ARADDR[ADDR_W-1:2];
	assign do_write = awh_reg & wh_reg & ~bv_reg;
	assign wr_sc    = do_write & ws_reg & (wr_idx == SERIAL_CONTROL_IDX);
	assign wr_bit   = do_write & ws_reg & (wr_idx == BIT_ACCESS_IDX);
	assign wr_pc    = do_write & ws_reg & (wr_idx == POWER_CONTROL_IDX);
	assign wr_data  = do_write & ws_reg & (wr_idx == DATA_BUFFER_IDX);
	assign wr_hit   = (wr_idx == SERIAL_CONTROL_IDX) |
		(wr_idx == BIT_ACCESS_IDX) | (wr_idx == POWER_CONTROL_IDX) |
		(wr_idx == DATA_BUFFER_IDX);
	// single-bit write: replace one bit of the current image
	assign bit_mask = 8'h01 << wd_reg[2:0];
	assign sc_val   = wr_bit ? ((sc_read & ~bit_mask) |
		(wd_reg[BA_VALUE] ? bit_mask : 8'h00)) : wd_reg;
	assign start_tx  = wr_data & (eng_reg == ENG_IDLE);
	assign start_rx0 = (eng_reg == ENG_IDLE) & ~start_tx &
		(mode == MODE_SHIFT) & ren_reg & ~ri_reg;
	assign restart  = (start_tx | start_rx0) & (mode == MODE_SHIFT);
	assign stop_idx = sm0_reg ? STOP_IDX_9 : STOP_IDX_8;
	// filter: mode 1 needs a good stop, modes 2/3 need ninth bit set
	assign rx_accept = rx_done & ~ri_reg & (~sm2_reg |
		(mode == MODE_UART8 ? rx_stop : rx_ninth));

	baud_tick_gen #(
		.DIV_W(DIV_MIN_W)
	) u_tick (
		.clk         (CLK),
		.rst_n       (RST_N),
		.mode        (mode),
		.baud_double (baud_double_select_reg),
		.double_speed(DOUBLE_SPEED),
		.timer_tick  (TIMER_TICK),
		.restart     (restart),
		.tick        (tick)
	);

	rx_frame #(
		.DATA_BITS(8)
	) u_rx (
		.clk      (CLK),
		.rst_n    (RST_N),
		.enable   (ren_reg & (mode != MODE_SHIFT)),
		.tick     (tick),
		.rxd      (RXD_IN),
		.nine_bit (sm0_reg),
		.done     (rx_done),
		.data_out (rx_data),
		.ninth_out(rx_ninth),
		.stop_out (rx_stop)
	);

	// ==========================================================
	// shift engine: mode 0 in both directions, async transmit
	always_comb begin
		eng_next   = eng_reg;
		shift_next = shift_reg;
		bit_next   = bit_reg;
		phase_next = phase_reg;
		txd_next   = txd_reg;
		rxo_next   = rxo_reg;
		oe_next    = oe_reg;
		ti_set     = 1'b0;
		ri_set     = 1'b0;
		rx_buf_next = rx_buf_reg;
		case (eng_reg)
		ENG_IDLE: begin
			txd_next = 1'b1;
			oe_next  = 1'b0;
			bit_next   = '0;
			phase_next = '0;
			if (start_tx && mode == MODE_SHIFT) begin
				eng_next   = ENG_TX0;
				shift_next = {2'b11, wd_reg};
				rxo_next   = wd_reg[0];
				oe_next    = 1'b1;
			end else if (start_tx) begin
				eng_next   = ENG_ASYNC;
				txd_next   = 1'b0;
				shift_next = {1'b1, sm0_reg ? tb8_reg : 1'b1,
					wd_reg};
			end else if (start_rx0) begin
				eng_next   = ENG_RX0;
				shift_next = '0;
			end
		end
		ENG_TX0, ENG_RX0: begin
			if (tick && !phase_reg[0]) begin
				txd_next   = 1'b0;
				phase_next = 4'h1;
			end else if (tick) begin
				txd_next   = 1'b1;
				phase_next = 4'h0;
				bit_next   = bit_reg + 4'h1;
				if (eng_reg == ENG_RX0) begin
					shift_next = {2'b00, RXD_IN, shift_reg[7:1]};
				end else begin
					shift_next = {1'b1, shift_reg[9:1]};
					rxo_next   = shift_reg[1];
				end
				if (bit_reg == M0_LAST_BIT) begin
					eng_next = ENG_IDLE;
					oe_next  = 1'b0;
					if (eng_reg == ENG_RX0) begin
						ri_set      = 1'b1;
						rx_buf_next = {RXD_IN, shift_reg[7:1]};
					end else begin
						ti_set = 1'b1;
					end
				end
			end
		end
		ENG_ASYNC: begin
			if (tick) begin
				phase_next = phase_reg + 4'h1;
				if (phase_reg == LAST_PHASE) begin
					if (bit_reg == stop_idx) begin
						eng_next = ENG_IDLE;
						txd_next = 1'b1;
					end else begin
						bit_next   = bit_reg + 4'h1;
						txd_next   = shift_reg[0];
						shift_next = {1'b1, shift_reg[9:1]};
						// stop bit begins now
						ti_set = (bit_reg + 4'h1) == stop_idx;
					end
				end
			end
		end
		default: eng_next = ENG_IDLE;
		endcase
		if (rx_accept)
			rx_buf_next = rx_data;
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			eng_reg    <= ENG_IDLE;
			shift_reg  <= '0;
			bit_reg    <= '0;
			phase_reg  <= '0;
			txd_reg    <= 1'b1;
			rxo_reg    <= 1'b1;
			oe_reg     <= 1'b0;
			rx_buf_reg <= '0;
		end else begin
			eng_reg    <= eng_next;
			shift_reg  <= shift_next;
			bit_reg    <= bit_next;
			phase_reg  <= phase_next;
			txd_reg    <= txd_next;
			rxo_reg    <= rxo_next;
			oe_reg     <= oe_next;
			rx_buf_reg <= rx_buf_next;
		end
	end

	// ==========================================================
	// control and power registers; hardware set beats software clear
	always_comb begin
		{sm0_next, sm1_next, sm2_next, ren_next} =
			{sm0_reg, sm1_reg, sm2_reg, ren_reg};
		{tb8_next, rb8_next, ti_next, ri_next, fe_next} =
			{tb8_reg, rb8_reg, ti_reg, ri_reg, fe_reg};
		{baud_double_select_next, frame_error_select_next} = {baud_double_select_reg, frame_error_select_reg};
		pflags_next = pflags_reg;
		if (wr_sc || wr_bit) begin
			if (frame_error_select_reg)
				fe_next = sc_val[SC_FE_SM0];
			else
				sm0_next = sc_val[SC_FE_SM0];
			sm1_next = sc_val[SC_SM1];
			sm2_next = sc_val[SC_SM2];
			ren_next = sc_val[SC_REN];
			tb8_next = sc_val[SC_TB8];
			rb8_next = sc_val[SC_RB8];
			ti_next  = sc_val[SC_TI];
			ri_next  = sc_val[SC_RI];
		end
		if (wr_pc) begin
			baud_double_select_next  = wd_reg[PC_BAUD_DOUBLE_SELECT];
			frame_error_select_next  = wd_reg[PC_FRAME_ERROR_SELECT];
			pflags_next = wd_reg[4:0];
		end
		if (ti_set)
			ti_next = 1'b1;
		if (ri_set || rx_accept)
			ri_next = 1'b1;
		if (rx_accept)
			rb8_next = sm0_reg ? rx_ninth : rx_stop;
		if (rx_done && !rx_stop)
			fe_next = 1'b1;
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			{sm0_reg, sm1_reg, sm2_reg, ren_reg,
				tb8_reg, rb8_reg, ti_reg, ri_reg} <= SERIAL_CONTROL_RST;
			fe_reg     <= 1'b0;
			baud_double_select_reg  <= 1'b0;
			frame_error_select_reg  <= 1'b0;
			pflags_reg <= POWER_FLAGS_RST;
		end else begin
			sm0_reg    <= sm0_next;
			sm1_reg    <= sm1_next;
			sm2_reg    <= sm2_next;
			ren_reg    <= ren_next;
			tb8_reg    <= tb8_next;
			rb8_reg    <= rb8_next;
			ti_reg     <= ti_next;
			ri_reg     <= ri_next;
			fe_reg     <= fe_next;
			baud_double_select_reg  <= baud_double_select_next;
			frame_error_select_reg  <= frame_error_select_next;
			pflags_reg <= pflags_next;
		end
	end

	// ==========================================================
	// AXI4-Lite slave
	always_comb begin
		awh_next = awh_reg;
		awa_next = awa_reg;
		wh_next  = wh_reg;
		wd_next  = wd_reg;
		ws_next  = ws_reg;
		bv_next  = bv_reg;
		br_next  = br_reg;
		rv_next  = rv_reg;
		rr_next  = rr_reg;
		rd_next  = rd_reg;
		if (AWVALID && !awh_reg) begin
			awh_next = 1'b1;
			awa_next = AWADDR;
		end
		if (WVALID && !wh_reg) begin
			wh_next = 1'b1;
			wd_next = WDATA[7:0];
			ws_next = WSTRB[0];
		end
		if (do_write) begin
			awh_next = 1'b0;
			wh_next  = 1'b0;
			bv_next  = 1'b1;
			br_next  = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bv_reg && BREADY) begin
			bv_next = 1'b0;
		end
		if (ARVALID && !rv_reg) begin
			rv_next = 1'b1;
			rr_next = RESP_OKAY;
			case (rd_idx)
			SERIAL_CONTROL_IDX, BIT_ACCESS_IDX: rd_next = sc_read;
			POWER_CONTROL_IDX: rd_next = pc_read;
			DATA_BUFFER_IDX:   rd_next = rx_buf_reg;
			default: begin
				rd_next = 8'h00;
				rr_next = RESP_SLVERR;
			end
			endcase
		end else if (rv_reg && RREADY) begin
			rv_next = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			awh_reg <= 1'b0;
			awa_reg <= '0;
			wh_reg  <= 1'b0;
			wd_reg  <= '0;
			ws_reg  <= 1'b0;
			bv_reg  <= 1'b0;
			br_reg  <= RESP_OKAY;
			rv_reg  <= 1'b0;
			rr_reg  <= RESP_OKAY;
			rd_reg  <= '0;
		end else begin
			awh_reg <= awh_next;
			awa_reg <= awa_next;
			wh_reg  <= wh_next;
			wd_reg  <= wd_next;
			ws_reg  <= ws_next;
			bv_reg  <= bv_next;
			br_reg  <= br_next;
			rv_reg  <= rv_next;
			rr_reg  <= rr_next;
			rd_reg  <= rd_next;
		end
	end

	assign AWREADY = ~awh_reg;
	assign WREADY  = ~wh_reg;
	assign BVALID  = bv_reg;
	assign BRESP   = br_reg;
	assign ARREADY = ~rv_reg;
	assign RVALID  = rv_reg;
	assign RRESP   = rr_reg;
	assign RDATA   = {24'h000000, rd_reg};
	assign TXD     = txd_reg;
	assign RXD_OUT = rxo_reg;
	assign RXD_OE  = oe_reg;
endmodule : serial_port_control

`default_nettype wire

// File: test/serial_port_control_properties.sv
// serial_port_control_properties: bus and shift clock checks at the pins.
// assumes: bound to serial_port_control, one clock domain.
`default_nettype none

module serial_port_control_properties (
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        AWVALID,
	input wire logic        AWREADY,
	input wire logic        WVALID,
	input wire logic        WREADY,
	input wire logic        BVALID,
	input wire logic        BREADY,
	input wire logic        ARVALID,
	input wire logic        ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic        RVALID,
	input wire logic        RREADY,
	input wire logic        DOUBLE_SPEED,
	input wire logic        TXD,
	input wire logic        RXD_OUT,
	input wire logic        RXD_OE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// ==========
	// register bus
	sequence s_both_taken; AWVALID && AWREADY && WVALID && WREADY; endsequence
	sequence s_low_half; !TXD [*6] ##1 TXD; endsequence
	property p_rst_idle;
		disable iff (1'b0) !RST_N |=> TXD && !RXD_OE && !BVALID && !RVALID;
	endproperty
	property p_wr_answer; s_both_taken |-> ##2 BVALID; endproperty
	property p_b_stands; BVALID && !BREADY |=> BVALID; endproperty
	property p_rd_answer; ARVALID && ARREADY |=> RVALID; endproperty
	property p_r_stands;
		RVALID && !RREADY |=> RVALID && $stable(RDATA);
	endproperty
	property p_r_release; RVALID && RREADY |=> !RVALID; endproperty
	// ==========
	// shift register mode
	property p_m0_half;
		$fell(TXD) && RXD_OE && !DOUBLE_SPEED |-> s_low_half;
	endproperty
	property p_m0_shift;
		RXD_OE && $past(RXD_OE) && $changed(RXD_OUT) |-> $rose(TXD);
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("reset levels");
	a_wr_answer: assert property (p_wr_answer) else $error("no bvalid");
	a_b_stands: assert property (p_b_stands) else $error("bvalid fell");
	a_rd_answer: assert property (p_rd_answer) else $error("no rvalid");
	a_r_stands: assert property (p_r_stands) else $error("rdata moved");
	a_r_release: assert property (p_r_release) else $error("rvalid held");
	a_m0_half: assert property (p_m0_half) else $error("low half length");
	a_m0_shift: assert property (p_m0_shift) else $error("data moved");
endmodule : serial_port_control_properties

bind serial_port_control serial_port_control_properties u_props (.*);

`default_nettype wire

// File: test/remote_port.sv
// remote_port: far end serial device, sends frames, captures the output.
// assumes: tasks are entered just after a clk edge.
`default_nettype none

module remote_port (
	input wire logic clk,
	input wire logic txd,
	input wire logic rxd_out,
	output var logic rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial rxd = 1'b1;

	task automatic send(input logic [10:0] f, input int n, per);
		for (int i = 0; i < n; i++) begin
			rxd <= f[i];
			repeat (per) @(posedge clk);
		end
		rxd <= 1'b1;
	endtask : send

	// samples mid bit, or mid low half of the shift clock
	task automatic recv(input int n, per, input bit m0, output logic [10:0] b);
		int k;
		b = '0;
		k = 0;
		while (txd !== 1'b0 && k < 5000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 5000) begin
			b = 'x;
			return;
		end
		repeat (m0 ? per / 4 : per / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			b[i] = m0 ? rxd_out : txd;
			repeat (per) @(posedge clk);
		end
	endtask : recv

	// mode 0 receive: next bit after each shift clock fall
	task automatic feed(input logic [7:0] d, output bit late);
		int k;
		k = 0;
		for (int i = 0; i < 8; i++) begin
			while (txd !== 1'b0 && k < 400) begin
				@(posedge clk);
				k++;
			end
			rxd <= d[i];
			while (txd !== 1'b1 && k < 400) begin
				@(posedge clk);
				k++;
			end
		end
		rxd <= 1'b1;
		late = k >= 400;
	endtask : feed
endmodule : remote_port

`default_nettype wire

// File: test/serial_port_control_tb.sv
// serial_port_control_tb: register level tests of the serial port.
// assumes: remote_port on the pins, checker bound to the design.
`default_nettype none

module serial_port_control_tb
	import serial_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [9:0] PC_A = {POWER_CONTROL_IDX, 2'b00};
	localparam logic [9:0] SC_A = {SERIAL_CONTROL_IDX, 2'b00};
	localparam logic [9:0] DB_A = {DATA_BUFFER_IDX, 2'b00};
	localparam logic [9:0] BA_A = {BIT_ACCESS_IDX, 2'b00};
	logic        CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, TIMER_TICK;
	logic        DOUBLE_SPEED, TXD, RXD_OUT, RXD_OE, rem_rxd;
	logic [9:0]  AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [3:0]  WSTRB;
	logic [1:0]  BRESP, RRESP;
	wire logic   rxd_line;
	int          n_errors, tests_run;

	assign rxd_line = RXD_OE ? RXD_OUT : rem_rxd;
	serial_port_control u_dut (.*, .RXD_IN(rxd_line));
	remote_port rem (.clk(CLK), .txd(TXD), .rxd_out(rxd_line), .rxd(rem_rxd));

	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end
	always @(posedge CLK) TIMER_TICK <= (TIMER_TICK !== 1'b1);

	// ==========
	// bus and compare tasks
	task automatic tally_and_finish;
		$display("compares %0d, errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] g, e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic bus(input bit w, input logic [9:0] a, input logic [7:0] d,
		output logic [31:0] q, output logic [1:0] r);
		int k;
		@(posedge CLK);
		AWADDR <= a;
		ARADDR <= a;
		WDATA <= {24'h0, d};
		AWVALID <= w;
		WVALID <= w;
		BREADY <= w;
		ARVALID <= !w;
		RREADY <= !w;
		k = 0;
		do begin
			@(posedge CLK);
			k++;
			if (AWREADY === 1'b1) AWVALID <= 1'b0;
			if (WREADY === 1'b1) WVALID <= 1'b0;
			if (ARREADY === 1'b1) ARVALID <= 1'b0;
		end while (!(w ? BVALID === 1'b1 : RVALID === 1'b1) && k < 40);
		BREADY <= 1'b0;
		RREADY <= 1'b0;
		q = RDATA;
		r = w ? BRESP : RRESP;
		if (k >= 40) begin
			n_errors++;
			tally_and_finish();
		end
	endtask : bus

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic [1:0]  r;
		bus(1'b1, a, d, q, r);
		chk(r, RESP_OKAY);
	endtask : wr

	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		logic [31:0] q;
		logic [1:0]  r;
		bus(1'b0, a, 8'h00, q, r);
		chk(q, {24'h0, e});
	endtask : rd

	// ==========
	// serial transfers
	task automatic txt(input logic [7:0] c, p, input bit x, input int n, per);
		logic [10:0] b, e;
		logic [7:0]  d;
		d = c ^ per[7:0] ^ 8'h5a;
		e = {1'b1, c[3], d, 1'b0};
		if (n == 10) e = {2'b01, d, 1'b0};
		if (n == 8) e = {3'h0, d};
		DOUBLE_SPEED <= x;
		wr(PC_A, p);
		wr(SC_A, c);
		wr(DB_A, d);
		rem.recv(n, per, n == 8, b);
		chk(b, e);
		rd(SC_A, c | 8'h02);
		wr(BA_A, 8'h01);
	endtask : txt

	task automatic rxt(input logic [7:0] d, input logic nb, st, input int n,
		input logic [7:0] e);
		logic [10:0] f;
		f = (n == 11) ? {st, nb, d, 1'b0} : {1'b1, st, d, 1'b0};
		rem.send(f, n, 64);
		rd(SC_A, e);
	endtask : rxt

	initial begin
		logic [31:0] q;
		logic [1:0]  r;
		bit          late;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
		{DOUBLE_SPEED, AWADDR, ARADDR, WDATA} = '0;
		WSTRB = 4'h1;
		RST_N = 1'b0;
		repeat (20) @(posedge CLK);
		RST_N <= 1'b1;
		rd(SC_A, 8'h00);
		rd(PC_A, 8'h10);
		wr(PC_A, 8'hff);
		rd(PC_A, 8'hdf);
		bus(1'b0, 10'h3fc, 8'h00, q, r);
		chk(r, RESP_SLVERR);
		txt(8'h88, 8'h00, 1'b0, 11, 64);
		txt(8'h80, 8'h80, 1'b0, 11, 32);
		txt(8'h88, 8'h00, 1'b1, 11, 32);
		txt(8'h80, 8'h80, 1'b1, 11, 16);
		txt(8'hc8, 8'h00, 1'b0, 11, 64);
		txt(8'h40, 8'h80, 1'b0, 10, 32);
		txt(8'h00, 8'h00, 1'b0, 8, 12);
		txt(8'h00, 8'h00, 1'b1, 8, 6);
		DOUBLE_SPEED <= 1'b0;
		wr(PC_A, 8'h00);
		wr(SC_A, 8'h90);
		wr(PC_A, 8'h40);
		rxt(8'h3c, 1'b1, 1'b1, 11, 8'h15);
		rxt(8'hc3, 1'b0, 1'b0, 11, 8'h95);
		rd(DB_A, 8'h3c);
		wr(BA_A, 8'h00);
		rxt(8'h66, 1'b0, 1'b1, 11, 8'h91);
		rd(DB_A, 8'h66);
		wr(SC_A, 8'h10);
		rd(SC_A, 8'h10);
		wr(PC_A, 8'h00);
		rd(BA_A, 8'h90);
		wr(SC_A, 8'h80);
		rxt(8'h55, 1'b1, 1'b1, 11, 8'h80);
		wr(SC_A, 8'hb0);
		rxt(8'h42, 1'b0, 1'b1, 11, 8'hb0);
		rxt(8'h81, 1'b1, 1'b1, 11, 8'hb5);
		wr(SC_A, 8'h50);
		rxt(8'h0f, 1'b0, 1'b1, 10, 8'h55);
		rd(DB_A, 8'h0f);
		wr(SC_A, 8'h10);
		rem.feed(8'ha6, late);
		chk(late, 1'b0);
		rd(SC_A, 8'h11);
		rd(DB_A, 8'ha6);
		wr(SC_A, 8'h00);
		tally_and_finish();
	end
endmodule : serial_port_control_tb

`default_nettype wire
